/* design/dfs_supervisor.sv */
// demand and feedback input supervisor with run interlock and discrete reset
//
// Our own choices: strobed register access and the address map.
`timescale 1ns/1ps

// How it works
// - minimum demand current (default 4 mA) maps to 0 % stroke
// - maximum current (default 20 mA) maps to 100 %, linear between
// - scaling save commits only in shutdown state, otherwise rejected and flagged
// - demand current below low or above high fault limit raises alarm
// - demand modes: channel 1, channel 2, average, lower, higher
// - dual mode with one valid demand runs on it, alarms the other
// - combined demand is average, lower or higher as mode selects
// - dual modes flag demand spread warning when difference exceeds limit
// - actual demand spread is exposed in percent
// - past spread limit, demand follows the spread fault mode
// - feedback modes: channel 1, channel 2, average
// - average feedback with one channel present uses it, alarms other
// - selected feedback value is used and exposed in percent
// - averaging feedback flags spread warning above feedback spread limit
// - used interlock open: demands ignored, shutdown
// - switching interlock to used while open shuts down at once
// - used interlock stays shut down until circuit closes
// - interlock not used: circuit state ignored
// - reset discrete closing clears alarms without a present cause and the demand loss shutdown
// - after reset run resumes only with valid demand and no shutdown cause
module dfs_supervisor (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // register port
    input wire dfs_pkg::dfs_bus_req_t bus_req,
    output logic [31:0] bus_rdata,
    // field inputs
    input wire dfs_pkg::dfs_in_t field_in,
    // supervised results
    output dfs_pkg::dfs_out_t sup_out
);
    import dfs_pkg::*;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [15:0] stage_min;
        logic [15:0] stage_max;
        logic [15:0] act_min;
        logic [15:0] act_max;
        logic [15:0] flt_lo;
        logic [15:0] flt_hi;
        logic [15:0] dspr_lim;
        logic [15:0] fspr_lim;
        dfs_state_t state;
        logic dmd_lost;
        logic dmd1_alm;
        logic dmd2_alm;
        logic fb1_alm;
        logic fb2_alm;
        logic dspr_warn;
        logic fspr_warn;
        logic save_rej;
        logic reset_prev;
        logic [15:0] dmd1_pct;
        logic [15:0] dmd2_pct;
        logic [15:0] demand;
        logic [15:0] feedback;
        logic [15:0] dspread;
        logic [15:0] fspread;
        logic [31:0] rdata;
    } dfs_reg_t;

    dfs_reg_t st_q;
    dfs_reg_t st_d;

    // linear mapping of a current onto 0..100 % of stroke
    function automatic logic [15:0] dfs_scale(logic [15:0] cur, logic [15:0] lo,
                                              logic [15:0] hi);
        logic [31:0] num;
        logic [31:0] den;
        logic [31:0] quo;
        num = 32'h0;
        den = 32'h0;
        quo = 32'h0;
        if (hi <= lo || cur <= lo) begin
            dfs_scale = DFS_PCT_ZERO;
        end else if (cur >= hi) begin
            dfs_scale = DFS_PCT_FULL;
        end else begin
            num = 32'(cur - lo) * 32'(DFS_PCT_FULL);
            den = 32'(hi - lo);
            quo = num / den;
            dfs_scale = quo[15:0];
        end
    endfunction : dfs_scale

    function automatic logic [15:0] dfs_absdiff(logic [15:0] a, logic [15:0] b);
        dfs_absdiff = (a > b) ? a - b : b - a;
    endfunction : dfs_absdiff

    function automatic logic [15:0] dfs_avg(logic [15:0] a, logic [15:0] b);
        logic [16:0] s;
        s = {1'b0, a} + {1'b0, b};
        dfs_avg = s[16:1];
    endfunction : dfs_avg

    function automatic logic [15:0] dfs_min(logic [15:0] a, logic [15:0] b);
        dfs_min = (a < b) ? a : b;
    endfunction : dfs_min

    function automatic logic [15:0] dfs_max(logic [15:0] a, logic [15:0] b);
        dfs_max = (a > b) ? a : b;
    endfunction : dfs_max

    // working values of the combinational process
    logic v1;
    logic v2;
    logic p1;
    logic p2;
    logic dual;
    logic ilk_shut;
    logic rst_edge;
    logic dspr_over;
    logic fspr_over;
    logic [15:0] s1;
    logic [15:0] s2;
    logic [15:0] both;
    logic [15:0] dmd_sel;
    logic [15:0] dsp;
    logic [15:0] fsp;
    logic [15:0] fb_sel;
    logic [15:0] status;
    dfs_dmode_t dmode;
    dfs_sfmode_t sfmode;
    dfs_fbmode_t fbmode;

    always_comb begin
        st_d = st_q;
        dmode = dfs_dmode_t'(st_q.ctrl[DFS_F_DMODE +: 3]);
        sfmode = dfs_sfmode_t'(st_q.ctrl[DFS_F_SFMODE +: 2]);
        fbmode = dfs_fbmode_t'(st_q.ctrl[DFS_F_FBMODE +: 2]);
        rst_edge = field_in.reset_closed && !st_q.reset_prev;
        st_d.reset_prev = field_in.reset_closed;

        // demand channels: validity window and scaling
        v1 = field_in.dmd1_ma >= st_q.flt_lo && field_in.dmd1_ma <= st_q.flt_hi;
        v2 = field_in.dmd2_ma >= st_q.flt_lo && field_in.dmd2_ma <= st_q.flt_hi;
        s1 = dfs_scale(field_in.dmd1_ma, st_q.act_min, st_q.act_max);
        s2 = dfs_scale(field_in.dmd2_ma, st_q.act_min, st_q.act_max);
        // codes 5 to 7 behave as averaging, so they are dual modes too
        dual = dmode != DFS_DM_CH1 && dmode != DFS_DM_CH2;

        // spread between the two demands
        dsp = (v1 && v2) ? dfs_absdiff(s1, s2) : DFS_PCT_ZERO;
        dspr_over = dual && v1 && v2 && dsp > st_q.dspr_lim;

        // combined value of two good demands
        both = dfs_avg(s1, s2);
        if (dspr_over) begin
            unique case (sfmode)
                DFS_SF_LOW: both = dfs_min(s1, s2);
                DFS_SF_HIGH: both = dfs_max(s1, s2);
                default: both = dfs_avg(s1, s2);
            endcase
        end else begin
            unique case (dmode)
                DFS_DM_LOW: both = dfs_min(s1, s2);
                DFS_DM_HIGH: both = dfs_max(s1, s2);
                default: both = dfs_avg(s1, s2);
            endcase
        end

        // mode selection, one good channel carries a dual mode
        unique case (dmode)
            DFS_DM_CH1: dmd_sel = s1;
            DFS_DM_CH2: dmd_sel = s2;
            default: dmd_sel = (v1 && v2) ? both : (v1 ? s1 : s2);
        endcase

        // feedback channels
        p1 = field_in.fb1_present;
        p2 = field_in.fb2_present;
        fsp = (p1 && p2) ? dfs_absdiff(field_in.fb1_pct, field_in.fb2_pct) : DFS_PCT_ZERO;
        fspr_over = fbmode != DFS_FB_CH1 && fbmode != DFS_FB_CH2 && p1 && p2
                    && fsp > st_q.fspr_lim;
        unique case (fbmode)
            DFS_FB_CH1: fb_sel = field_in.fb1_pct;
            DFS_FB_CH2: fb_sel = field_in.fb2_pct;
            default: begin
                if (p1 && p2) begin
                    fb_sel = dfs_avg(field_in.fb1_pct, field_in.fb2_pct);
                end else if (p2) begin
                    fb_sel = field_in.fb2_pct;
                end else begin
                    fb_sel = field_in.fb1_pct;
                end
            end
        endcase

        // interlock: live shutdown cause, ignored when not used
        // a write that turns the interlock on acts in the same cycle
        ilk_shut = ((bus_req.wr && bus_req.addr == DFS_A_CTRL) ? bus_req.wdata[DFS_F_RUNUSE]
                    : st_q.ctrl[DFS_F_RUNUSE]) && !field_in.run_closed;

        // alarms are sticky; a present cause wins over the discrete reset
        if (rst_edge) begin
            st_d.dmd1_alm = 1'b0;
            st_d.dmd2_alm = 1'b0;
            st_d.fb1_alm = 1'b0;
            st_d.fb2_alm = 1'b0;
            st_d.dspr_warn = 1'b0;
            st_d.fspr_warn = 1'b0;
            st_d.save_rej = 1'b0;
            st_d.dmd_lost = 1'b0;
        end
        if (!v1 && dmode != DFS_DM_CH2) begin
            st_d.dmd1_alm = 1'b1;
        end
        if (!v2 && dmode != DFS_DM_CH1) begin
            st_d.dmd2_alm = 1'b1;
        end
        if (!p1 && fbmode != DFS_FB_CH2) begin
            st_d.fb1_alm = 1'b1;
        end
        if (!p2 && fbmode != DFS_FB_CH1) begin
            st_d.fb2_alm = 1'b1;
        end
        if (dspr_over) begin
            st_d.dspr_warn = 1'b1;
        end
        if (fspr_over) begin
            st_d.fspr_warn = 1'b1;
        end
        // loss of every usable demand latches a shutdown until reset
        unique case (dmode)
            DFS_DM_CH1: if (!v1) st_d.dmd_lost = 1'b1;
            DFS_DM_CH2: if (!v2) st_d.dmd_lost = 1'b1;
            default: if (!v1 && !v2) st_d.dmd_lost = 1'b1;
        endcase

        // operating state
        unique case (st_q.state)
            DFS_ST_RUN: begin
                if (ilk_shut || st_d.dmd_lost) begin
                    st_d.state = DFS_ST_SHUT;
                end
            end
            DFS_ST_SHUT: begin
                if (!ilk_shut && !st_d.dmd_lost) begin
                    st_d.state = DFS_ST_RUN;
                end
            end
            default: st_d.state = DFS_ST_SHUT;
        endcase

        // published values; demands are ignored while shut down
        st_d.dmd1_pct = s1;
        st_d.dmd2_pct = s2;
        st_d.demand = (st_d.state == DFS_ST_RUN) ? dmd_sel : DFS_PCT_ZERO;
        st_d.feedback = fb_sel;
        st_d.dspread = dsp;
        st_d.fspread = fsp;

        status = 16'h0;
        status[DFS_S_SHUT] = st_q.state == DFS_ST_SHUT;
        status[DFS_S_DMD1_ALM] = st_q.dmd1_alm;
        status[DFS_S_DMD2_ALM] = st_q.dmd2_alm;
        status[DFS_S_FB1_ALM] = st_q.fb1_alm;
        status[DFS_S_FB2_ALM] = st_q.fb2_alm;
        status[DFS_S_DSPR_WARN] = st_q.dspr_warn;
        status[DFS_S_FSPR_WARN] = st_q.fspr_warn;
        status[DFS_S_SAVE_REJ] = st_q.save_rej;
        status[DFS_S_ILK_OPEN] = !field_in.run_closed;
        status[DFS_S_ANY_ALM] = st_q.dmd1_alm | st_q.dmd2_alm | st_q.fb1_alm
                                | st_q.fb2_alm | st_q.dspr_warn | st_q.fspr_warn;

        // register writes
        if (bus_req.wr) begin
            unique case (bus_req.addr)
                DFS_A_CTRL: st_d.ctrl = bus_req.wdata[7:0];
                DFS_A_DMD_MIN: st_d.stage_min = bus_req.wdata[15:0];
                DFS_A_DMD_MAX: st_d.stage_max = bus_req.wdata[15:0];
                DFS_A_SAVE: begin
                    if (bus_req.wdata[0]) begin
                        if (st_q.state == DFS_ST_SHUT) begin
                            st_d.act_min = st_q.stage_min;
                            st_d.act_max = st_q.stage_max;
                        end else begin
                            st_d.save_rej = 1'b1;
                        end
                    end
                end
                DFS_A_FLT_LO: st_d.flt_lo = bus_req.wdata[15:0];
                DFS_A_FLT_HI: st_d.flt_hi = bus_req.wdata[15:0];
                DFS_A_DSPR_LIM: st_d.dspr_lim = bus_req.wdata[15:0];
                DFS_A_FSPR_LIM: st_d.fspr_lim = bus_req.wdata[15:0];
                default: st_d.ctrl = st_q.ctrl;
            endcase
        end

        // register reads, data valid in the next cycle only
        st_d.rdata = 32'h0;
        if (bus_req.rd) begin
            unique case (bus_req.addr)
                DFS_A_CTRL: st_d.rdata = {24'h0, st_q.ctrl};
                DFS_A_DMD_MIN: st_d.rdata = {16'h0, st_q.stage_min};
                DFS_A_DMD_MAX: st_d.rdata = {16'h0, st_q.stage_max};
                DFS_A_FLT_LO: st_d.rdata = {16'h0, st_q.flt_lo};
                DFS_A_FLT_HI: st_d.rdata = {16'h0, st_q.flt_hi};
                DFS_A_DSPR_LIM: st_d.rdata = {16'h0, st_q.dspr_lim};
                DFS_A_FSPR_LIM: st_d.rdata = {16'h0, st_q.fspr_lim};
                DFS_A_STATUS: st_d.rdata = {16'h0, status};
                DFS_A_DEMAND: st_d.rdata = {16'h0, st_q.demand};
                DFS_A_FEEDBACK: st_d.rdata = {16'h0, st_q.feedback};
                DFS_A_DSPREAD: st_d.rdata = {16'h0, st_q.dspread};
                DFS_A_FSPREAD: st_d.rdata = {16'h0, st_q.fspread};
                DFS_A_DMD1: st_d.rdata = {16'h0, st_q.dmd1_pct};
                DFS_A_DMD2: st_d.rdata = {16'h0, st_q.dmd2_pct};
                DFS_A_ACT_MIN: st_d.rdata = {16'h0, st_q.act_min};
                DFS_A_ACT_MAX: st_d.rdata = {16'h0, st_q.act_max};
                default: st_d.rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= '0;
            st_q.ctrl <= DFS_RST_CTRL;
            st_q.stage_min <= DFS_RST_DMD_MIN;
            st_q.stage_max <= DFS_RST_DMD_MAX;
            st_q.act_min <= DFS_RST_DMD_MIN;
            st_q.act_max <= DFS_RST_DMD_MAX;
            st_q.flt_lo <= DFS_RST_FLT_LO;
            st_q.flt_hi <= DFS_RST_FLT_HI;
            st_q.dspr_lim <= DFS_RST_SPREAD;
            st_q.fspr_lim <= DFS_RST_SPREAD;
            st_q.state <= DFS_ST_SHUT;
        end else begin
            st_q <= st_d;
        end
    end

    assign bus_rdata = st_q.rdata;
    assign sup_out.demand_pct = st_q.demand;
    assign sup_out.feedback_pct = st_q.feedback;
    assign sup_out.dmd_spread = st_q.dspread;
    assign sup_out.fb_spread = st_q.fspread;
    assign sup_out.shutdown = st_q.state == DFS_ST_SHUT;
    assign sup_out.alarm = st_q.dmd1_alm | st_q.dmd2_alm | st_q.fb1_alm | st_q.fb2_alm;
    assign sup_out.dmd_spread_warn = st_q.dspr_warn;
    assign sup_out.fb_spread_warn = st_q.fspr_warn;

endmodule : dfs_supervisor

/* pkg/dfs_pkg.sv */
// package: constants, modes and carrier types of the demand/feedback supervisor
package dfs_pkg;

    // units: currents in 0.01 mA codes, positions in 0.01 % codes
    localparam int DFS_DW = 16;
    localparam logic [15:0] DFS_PCT_FULL = 16'h2710;      // 100.00 %
    localparam logic [15:0] DFS_PCT_ZERO = 16'h0000;      // 0.00 %

    // reset values of the configuration
    localparam logic [15:0] DFS_RST_DMD_MIN = 16'h0190;   // 4.00 mA
    localparam logic [15:0] DFS_RST_DMD_MAX = 16'h07d0;   // 20.00 mA
    localparam logic [15:0] DFS_RST_FLT_LO = 16'h00c8;    // 2.00 mA
    localparam logic [15:0] DFS_RST_FLT_HI = 16'h0898;    // 22.00 mA
    localparam logic [15:0] DFS_RST_SPREAD = 16'h01f4;    // 5.00 %
    localparam logic [7:0] DFS_RST_CTRL = 8'hd2;          // dual avg, fault avg, fb avg, used

    // register byte addresses
    localparam logic [7:0] DFS_A_CTRL = 8'h00;
    localparam logic [7:0] DFS_A_DMD_MIN = 8'h04;
    localparam logic [7:0] DFS_A_DMD_MAX = 8'h08;
    localparam logic [7:0] DFS_A_SAVE = 8'h0c;
    localparam logic [7:0] DFS_A_FLT_LO = 8'h10;
    localparam logic [7:0] DFS_A_FLT_HI = 8'h14;
    localparam logic [7:0] DFS_A_DSPR_LIM = 8'h18;
    localparam logic [7:0] DFS_A_FSPR_LIM = 8'h1c;
    localparam logic [7:0] DFS_A_STATUS = 8'h20;
    localparam logic [7:0] DFS_A_DEMAND = 8'h24;
    localparam logic [7:0] DFS_A_FEEDBACK = 8'h28;
    localparam logic [7:0] DFS_A_DSPREAD = 8'h2c;
    localparam logic [7:0] DFS_A_FSPREAD = 8'h30;
    localparam logic [7:0] DFS_A_DMD1 = 8'h34;
    localparam logic [7:0] DFS_A_DMD2 = 8'h38;
    localparam logic [7:0] DFS_A_ACT_MIN = 8'h3c;
    localparam logic [7:0] DFS_A_ACT_MAX = 8'h40;

    // control register field positions
    localparam int DFS_F_DMODE = 0;     // [2:0]
    localparam int DFS_F_SFMODE = 3;    // [4:3]
    localparam int DFS_F_FBMODE = 5;    // [6:5]
    localparam int DFS_F_RUNUSE = 7;    // [7]

    // status register bit positions
    localparam int DFS_S_SHUT = 0;
    localparam int DFS_S_DMD1_ALM = 1;
    localparam int DFS_S_DMD2_ALM = 2;
    localparam int DFS_S_FB1_ALM = 3;
    localparam int DFS_S_FB2_ALM = 4;
    localparam int DFS_S_DSPR_WARN = 5;
    localparam int DFS_S_FSPR_WARN = 6;
    localparam int DFS_S_SAVE_REJ = 7;
    localparam int DFS_S_ILK_OPEN = 8;
    localparam int DFS_S_ANY_ALM = 9;

    typedef enum logic [2:0] {
        DFS_DM_CH1 = 3'h0,
        DFS_DM_CH2 = 3'h1,
        DFS_DM_AVG = 3'h2,
        DFS_DM_LOW = 3'h3,
        DFS_DM_HIGH = 3'h4
    } dfs_dmode_t;

    typedef enum logic [1:0] {
        DFS_SF_LOW = 2'h0,
        DFS_SF_HIGH = 2'h1,
        DFS_SF_AVG = 2'h2
    } dfs_sfmode_t;

    typedef enum logic [1:0] {
        DFS_FB_CH1 = 2'h0,
        DFS_FB_CH2 = 2'h1,
        DFS_FB_AVG = 2'h2
    } dfs_fbmode_t;

    // operating state, gray along run -> shut
    typedef enum logic [1:0] {
        DFS_ST_RUN = 2'b00,
        DFS_ST_SHUT = 2'b01
    } dfs_state_t;

    // register port carrier
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } dfs_bus_req_t;

    // digitised inputs from converters and contacts
    typedef struct packed {
        logic [15:0] dmd1_ma;
        logic [15:0] dmd2_ma;
        logic [15:0] fb1_pct;
        logic [15:0] fb2_pct;
        logic fb1_present;
        logic fb2_present;
        logic run_closed;
        logic reset_closed;
    } dfs_in_t;

    // supervised results
    typedef struct packed {
        logic [15:0] demand_pct;
        logic [15:0] feedback_pct;
        logic [15:0] dmd_spread;
        logic [15:0] fb_spread;
        logic shutdown;
        logic alarm;
        logic dmd_spread_warn;
        logic fb_spread_warn;
    } dfs_out_t;

endpackage : dfs_pkg

/* test/dfs_field_src.sv */
// field side model: demand sources, position sensors and contacts
`timescale 1ns/1ps
module dfs_field_src (
    // clock
    input wire logic clk,
    // wanted field state, and a freeze that makes the sources slow
    input wire dfs_pkg::dfs_in_t want,
    input wire logic hold,
    // toward the supervisor
    output dfs_pkg::dfs_in_t field_in
);
    import dfs_pkg::*;
    initial field_in = '0;
    // contacts open or close only when the bench commands it
    always @(posedge clk) begin
        if (!hold) begin
            field_in <= want;
        end
    end
endmodule : dfs_field_src

/* test/dfs_supervisor_props.sv */
// concurrent checks on the supervisor ports
`timescale 1ns/1ps
module dfs_supervisor_props (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // register port
    input wire dfs_pkg::dfs_bus_req_t bus_req,
    input wire logic [31:0] bus_rdata,
    // field side and results
    input wire dfs_pkg::dfs_in_t field_in,
    input wire dfs_pkg::dfs_out_t sup_out
);
    import dfs_pkg::*;
    logic [7:0] ctrl_q;
    logic [15:0] flim_q;
    logic [15:0] fb_abs;
    logic quiet;
    logic both_fb;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    assign quiet = !bus_req.wr;
    assign both_fb = field_in.fb1_present && field_in.fb2_present;
    assign fb_abs = (field_in.fb1_pct > field_in.fb2_pct) ?
        field_in.fb1_pct - field_in.fb2_pct : field_in.fb2_pct - field_in.fb1_pct;
    // shadow copies of control and feedback spread limit
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_q <= DFS_RST_CTRL;
            flim_q <= DFS_RST_SPREAD;
        end else if (bus_req.wr && bus_req.addr == DFS_A_CTRL) begin
            ctrl_q <= bus_req.wdata[7:0];
        end else if (bus_req.wr && bus_req.addr == DFS_A_FSPR_LIM) begin
            flim_q <= bus_req.wdata[15:0];
        end
    end
    a_read_limit: assert property (bus_req.rd && bus_req.addr == DFS_A_FSPR_LIM
        |=> bus_rdata == {16'h0, flim_q}) else $error("limit readback wrong");
    a_shut_zero: assert property (sup_out.shutdown |-> sup_out.demand_pct == DFS_PCT_ZERO)
        else $error("demand not zero in shutdown");
    a_ilk_open: assert property (quiet && ctrl_q[7] && !field_in.run_closed
        |=> sup_out.shutdown) else $error("open interlock did not shut down");
    a_ilk_toggle: assert property (bus_req.wr && bus_req.addr == DFS_A_CTRL
        && bus_req.wdata[7] && !field_in.run_closed |=> sup_out.shutdown)
        else $error("enabling interlock while open did not shut down");
    a_fb_spread: assert property (both_fb |=> sup_out.fb_spread == $past(fb_abs))
        else $error("feedback spread wrong");
    a_fb_warn: assert property (quiet && ctrl_q[6] && both_fb && fb_abs > flim_q
        |=> sup_out.fb_spread_warn) else $error("feedback spread warning missing");
    a_fb_chan1: assert property (quiet && ctrl_q[6:5] == 2'h0 && field_in.fb1_present
        |=> sup_out.feedback_pct == $past(field_in.fb1_pct)) else $error("fb ch1 wrong");
    a_fb_single: assert property (quiet && ctrl_q[6] && field_in.fb1_present
        && !field_in.fb2_present |=> sup_out.feedback_pct == $past(field_in.fb1_pct)
        && sup_out.alarm) else $error("single feedback handling wrong");
    c_shut_leave: cover property (sup_out.shutdown ##1 !sup_out.shutdown);
    c_fb_warn: cover property ($rose(sup_out.fb_spread_warn));
    c_alarm: cover property ($rose(sup_out.alarm));
endmodule : dfs_supervisor_props

/* test/demand_feedback_input_supervisor_test.sv */
// self-checking bench for the demand and feedback supervisor
`timescale 1ns/1ps
module demand_feedback_input_supervisor_test;
    import dfs_pkg::*;
    logic clk, reset_n, hold;
    dfs_bus_req_t bus_req;
    logic [31:0] bus_rdata, v;
    dfs_in_t want, field_in;
    dfs_out_t sup_out;
    int failures, n_tests, cycles, seed, i;
    logic [7:0] ctrl;
    logic [15:0] p1, p2;
    logic [39:0] regs [6] = '{40'h00000000d2, 40'h0400000190, 40'h08000007d0,
        40'h1c000001f4, 40'h40000007d0, 40'h4400000000};
    logic [15:0] bad [2] = '{16'h00c7, 16'h0899};

    dfs_supervisor dfs_supervisor_i (.clk(clk), .reset_n(reset_n), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .field_in(field_in), .sup_out(sup_out));
    dfs_field_src dfs_field_src_i (.clk(clk), .want(want), .hold(hold), .field_in(field_in));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles > 5000) begin
            failures++;
            end_sim();
        end
    end
    function automatic int rnd(input int n);
        return int'($unsigned($random(seed)) % n);
    endfunction : rnd
    function automatic logic [15:0] pct(input logic [15:0] ma, lo, hi);
        int r;
        r = (int'(ma) - int'(lo)) * 10000 / (int'(hi) - int'(lo));
        return (r < 0) ? 16'h0 : (r > 10000) ? DFS_PCT_FULL : 16'(r);
    endfunction : pct
    function automatic logic [15:0] diff(input logic [15:0] a, b);
        return (a > b) ? a - b : b - a;
    endfunction : diff
    function automatic logic [15:0] pick(input logic [15:0] a, b, input logic [2:0] m);
        case (m)
            3'h0: return a;
            3'h1: return b;
            3'h3: return (a < b) ? a : b;
            3'h4: return (a > b) ? a : b;
            default: return 16'((17'(a) + 17'(b)) >> 1);
        endcase
    endfunction : pick
    function automatic logic [2:0] dmode(input logic [7:0] c, input logic [15:0] sp);
        if (c[2:0] < 3'h2 || sp <= DFS_RST_SPREAD) return c[2:0];
        return (c[4:3] == 2'h0) ? 3'h3 : (c[4:3] == 2'h1) ? 3'h4 : 3'h2;
    endfunction : dmode
    task automatic chk(input logic [31:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus_req.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus_req.rd <= 1'b0;
        #1;
        d = bus_rdata;
    endtask : rd
    task automatic pulse_reset();
        @(posedge clk);
        want.reset_closed <= 1'b1;
        @(posedge clk);
        want.reset_closed <= 1'b0;
        settle(3);
    endtask : pulse_reset
    task automatic end_sim();
        $display("checks %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_sim

    initial begin
        seed = 32'ha256;
        failures = 0;
        n_tests = 0;
        cycles = 0;
        reset_n = 1'b0;
        hold = 1'b0;
        bus_req = '0;
        want = '{16'h04b0, 16'h04b0, 16'h1388, 16'h1388, 1'b1, 1'b1, 1'b1, 1'b0};
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        settle(3);
        chk(sup_out.shutdown, 32'h0);
        chk(sup_out.demand_pct, 32'h1388);
        foreach (regs[k]) begin
            rd(regs[k][39:32], v);
            chk(v, regs[k][31:0]);
        end
        $display("register defaults done");
        for (i = 0; i < 30; i++) begin
            ctrl = {1'b1, 2'(rnd(3)), 2'(rnd(3)), 3'(rnd(5))};
            wr(DFS_A_CTRL, {24'h0, ctrl});
            @(posedge clk);
            want.dmd1_ma <= (i == 0) ? DFS_RST_DMD_MIN : 16'(200 + rnd(2001));
            want.dmd2_ma <= (i == 0) ? DFS_RST_DMD_MAX : 16'(200 + rnd(2001));
            want.fb1_pct <= 16'(rnd(10001));
            want.fb2_pct <= 16'(rnd(10001));
            hold <= 1'(rnd(2));
            @(posedge clk);
            hold <= 1'b0;
            settle(3);
            p1 = pct(want.dmd1_ma, DFS_RST_DMD_MIN, DFS_RST_DMD_MAX);
            p2 = pct(want.dmd2_ma, DFS_RST_DMD_MIN, DFS_RST_DMD_MAX);
            chk(sup_out.dmd_spread, diff(p1, p2));
            chk(sup_out.demand_pct, pick(p1, p2, dmode(ctrl, diff(p1, p2))));
            chk(sup_out.feedback_pct, pick(want.fb1_pct, want.fb2_pct, {1'b0, ctrl[6:5]}));
            if (diff(p1, p2) > DFS_RST_SPREAD && ctrl[2:0] > 3'h1) begin
                chk(sup_out.dmd_spread_warn, 32'h1);
            end
        end
        $display("random mode sweep done");
        wr(DFS_A_CTRL, 32'hd2);
        foreach (bad[k]) begin
            @(posedge clk);
            want.dmd1_ma <= 16'h04b0;
            want.dmd2_ma <= bad[k];
            settle(3);
            chk(sup_out.alarm, 32'h1);
            chk(sup_out.demand_pct, 32'h1388);
            @(posedge clk);
            want.dmd2_ma <= 16'h04b0;
            pulse_reset();
            chk(sup_out.alarm, 32'h0);
        end
        $display("demand limits done");
        @(posedge clk);
        want.run_closed <= 1'b0;
        settle(3);
        chk(sup_out.shutdown, 32'h1);
        wr(DFS_A_DMD_MIN, 32'h320);
        wr(DFS_A_SAVE, 32'h1);
        rd(DFS_A_ACT_MIN, v);
        chk(v, 32'h320);
        wr(DFS_A_CTRL, 32'h52);
        settle(2);
        chk(sup_out.shutdown, 32'h0);
        chk(sup_out.demand_pct, pct(16'h04b0, 16'h0320, DFS_RST_DMD_MAX));
        wr(DFS_A_CTRL, 32'hd2);
        settle(2);
        chk(sup_out.shutdown, 32'h1);
        @(posedge clk);
        want.run_closed <= 1'b1;
        settle(3);
        chk(sup_out.shutdown, 32'h0);
        wr(DFS_A_DMD_MIN, 32'h190);
        wr(DFS_A_SAVE, 32'h1);
        rd(DFS_A_ACT_MIN, v);
        chk(v, 32'h320);
        rd(DFS_A_STATUS, v);
        chk(v[DFS_S_SAVE_REJ], 32'h1);
        $display("interlock and save done");
        @(posedge clk);
        want.fb1_pct <= 16'h03e8;
        want.fb2_present <= 1'b0;
        settle(3);
        chk(sup_out.feedback_pct, 32'h03e8);
        chk(sup_out.alarm, 32'h1);
        @(posedge clk);
        want.fb2_present <= 1'b1;
        want.dmd1_ma <= 16'h0;
        want.dmd2_ma <= 16'h0;
        settle(3);
        chk(sup_out.shutdown, 32'h1);
        @(posedge clk);
        want.dmd1_ma <= 16'h04b0;
        want.dmd2_ma <= 16'h04b0;
        settle(3);
        chk(sup_out.shutdown, 32'h1);
        pulse_reset();
        chk(sup_out.shutdown, 32'h0);
        chk(sup_out.alarm, 32'h0);
        $display("feedback loss and reset done");
        end_sim();
    end
endmodule : demand_feedback_input_supervisor_test

bind dfs_supervisor dfs_supervisor_props dfs_supervisor_props_i (.clk(clk), .reset_n(reset_n),
    .bus_req(bus_req), .bus_rdata(bus_rdata), .field_in(field_in), .sup_out(sup_out));
